/* hw/dcpm_pkg.sv */
// Purpose: Shared constants and carrier types for the DRAM clock-enable power manager.
// Assumes: 50 MHz command clock, four ranks per channel.
// Notes:   Timing figures are kept in their own units and converted to cycles here.
package dcpm_pkg;
  localparam int          DCPM_RANKS          = 4;
  localparam int          DCPM_CLK_MHZ        = 50;
  localparam int          DCPM_INIT_US        = 200;
  // Least time rounds up; the power-up hold is counted well past it (double).
  localparam int          DCPM_INIT_CYC       = DCPM_INIT_US * DCPM_CLK_MHZ * 2;
  localparam int          DCPM_EXIT_CYC_DEF   = 4;
  localparam int          DCPM_TYPE_HI        = 15;
  localparam int          DCPM_TYPE_LO        = 12;
  localparam int          DCPM_IDLE_HI        = 11;
  localparam int          DCPM_IDLE_LO        = 0;
  localparam logic [3:0]  DCPM_PD_NONE        = 4'h0;
  localparam logic [3:0]  DCPM_PD_OPEN_PAGE   = 4'h1;
  localparam logic [3:0]  DCPM_PD_PRECHARGED  = 4'h2;
  localparam logic [2:0]  DCPM_CSTATE_C3      = 3'h3;
  localparam logic [3:0]  DCPM_MASK_ZERO      = 4'h0;
  localparam logic [11:0] DCPM_CNT_ZERO       = 12'h000;

  typedef enum logic [1:0] {DCPM_DDR4, DCPM_DDR5, DCPM_LPDDR4, DCPM_LPDDR5} dcpm_tech_t;

  typedef enum {DCPM_INIT, DCPM_RUN, DCPM_DRAIN, DCPM_SELF_REF, DCPM_REF_UP, DCPM_REF_WAIT} dcpm_state_t;

  // Firmware configuration bundle.
  typedef struct packed {
    logic                  cke_release;
    logic [15:0]           pd_config;
    logic [DCPM_RANKS-1:0] populated;
    logic [DCPM_RANKS-1:0] graphics_ranks;
    dcpm_tech_t            tech;
  } dcpm_cfg_t;

  // Per-rank pin drive toward the DRAM.
  typedef struct packed {
    logic [DCPM_RANKS-1:0] cke;
    logic [DCPM_RANKS-1:0] cs_pd;
    logic [DCPM_RANKS-1:0] out_en_n;
    logic [DCPM_RANKS-1:0] rx_enable;
  } dcpm_pins_t;
endpackage

/* hw/dcpm_rank_idle.sv */
// Purpose: One rank's idle counter and power-down decision.
// Assumes: Threshold counted in command clocks; zero disables dynamic power-down.
// Notes:   The counter restarts on every transaction that arrives for this rank.
module dcpm_rank_idle (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Control
  input  wire logic        enable,
  input  wire logic        txn_arrive,
  input  wire logic        txn_queued,
  input  wire logic [11:0] threshold,
  // Result
  output logic             expired
);
  import dcpm_pkg::*;

  typedef struct packed {
    logic [11:0] cnt;
    logic        exp;
  } dcpm_idle_st_t;

  dcpm_idle_st_t st_reg;
  dcpm_idle_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (!enable || txn_arrive || txn_queued || threshold == DCPM_CNT_ZERO) begin
      st_next.cnt = DCPM_CNT_ZERO;
      st_next.exp = 1'b0;
    end else if (st_reg.cnt >= threshold - 12'h001) begin
      st_next.exp = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign expired = st_reg.exp;

  a_idle_restart: assert property (@(posedge clk) disable iff (!rstn)
    txn_arrive |=> !expired) else $error("Idle flag set right after a transaction.");
endmodule

/* hw/dcpm_top.sv */
// Purpose: DRAM clock-enable and chip-select power manager for one channel.
// Assumes: Request queues and the refresh scheduler sit outside; inputs are synchronous to clk.
// Notes:   Command issue is gated by cmd_allow; the scheduler must honour it.
// Operation
// - Hold clock enable low throughout power-up.
// - Clock enable stays low under reset until firmware sets the release bit.
// - Inactive clock-enable interval lasts well beyond 200 microseconds.
// - DDR5 and LPDDR5 use chip select for power-state control.
// - Enter self-refresh in package C3 or deeper with no pending requests.
// - Suspend or conditional self-refresh drains first, then self-refreshes non-graphics ranks.
// - Power down each rank independently from its own idle state.
// - Type field picks open-page or precharged power-down; precharged closes pages first.
// - Power all ranks up before refresh, down again after it completes.
// - Per-rank clock enable stays low for unpopulated ranks; their chip-select power-down pin stays deasserted.
// - Unused signals: driver off from the first clock after reset, receiver off, input path gated.
// - Keep clock enable at its level while supplies are gated.
// - Skip retraining on resume; restore stored training results.
// - Type in bits 15:12, idle threshold in command clocks in bits 11:0.
// - Idle counter restarts on each arrival; expiry plus empty queue permits power-down.
module dcpm_top #(
  parameter int INIT_CYC = dcpm_pkg::DCPM_INIT_CYC,
  parameter int EXIT_CYC = dcpm_pkg::DCPM_EXIT_CYC_DEF
) (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            rstn,
  // Firmware configuration
  input  wire dcpm_pkg::dcpm_cfg_t             cfg,
  input  wire logic                            training_valid,
  // Package power state
  input  wire logic [2:0]                      pkg_cstate,
  input  wire logic                            suspend_req,
  input  wire logic                            cond_sr_req,
  input  wire logic                            supply_gated,
  // Request queues
  input  wire logic [dcpm_pkg::DCPM_RANKS-1:0] txn_arrive,
  input  wire logic [dcpm_pkg::DCPM_RANKS-1:0] txn_queued,
  input  wire logic                            cycles_pending,
  input  wire logic [dcpm_pkg::DCPM_RANKS-1:0] pages_open,
  input  wire logic                            pages_closed_ack,
  // Refresh scheduler
  input  wire logic                            refresh_req,
  input  wire logic                            refresh_done,
  // DRAM side
  output dcpm_pkg::dcpm_pins_t                 pins,
  output logic [dcpm_pkg::DCPM_RANKS-1:0]      self_refresh,
  // Status and commands toward the scheduler
  output logic                                 precharge_all_req,
  output logic                                 refresh_go,
  output logic [dcpm_pkg::DCPM_RANKS-1:0]      cmd_allow,
  output logic                                 skip_training,
  output logic                                 init_done
);
  import dcpm_pkg::*;

  localparam int CNT_W = $clog2(INIT_CYC + 1);

  typedef struct packed {
    dcpm_state_t          state;
    logic [CNT_W-1:0]     init_cnt;
    logic                 hold_done;
    logic [DCPM_RANKS-1:0] pd;
    logic [DCPM_RANKS-1:0] sr;
    logic [DCPM_RANKS-1:0] allow;
    logic [DCPM_RANKS-1:0][7:0] exit_cnt;
    logic                 pre_req;
    logic                 ref_go;
    logic                 trained;
    dcpm_pins_t           pins;
  } dcpm_st_t;

  dcpm_st_t              st_reg;
  dcpm_st_t              st_next;
  logic [DCPM_RANKS-1:0] idle_exp;
  logic [3:0]            pd_type;
  logic [11:0]           idle_thr;
  logic                  pd_en;
  logic                  cs_based;
  logic                  deep_idle;

  assign pd_type   = cfg.pd_config[DCPM_TYPE_HI:DCPM_TYPE_LO];
  assign idle_thr  = cfg.pd_config[DCPM_IDLE_HI:DCPM_IDLE_LO];
  assign pd_en     = (pd_type == DCPM_PD_OPEN_PAGE) || (pd_type == DCPM_PD_PRECHARGED);
  assign cs_based  = (cfg.tech == DCPM_DDR5) || (cfg.tech == DCPM_LPDDR5);
  assign deep_idle = pkg_cstate >= DCPM_CSTATE_C3;

  genvar g;
  generate
    for (g = 0; g < DCPM_RANKS; g++) begin : g_idle
      dcpm_rank_idle u_idle (
        .clk        (clk),
        .rstn       (rstn),
        .enable     (pd_en && cfg.populated[g] && st_reg.state == DCPM_RUN),
        .txn_arrive (txn_arrive[g]),
        .txn_queued (txn_queued[g]),
        .threshold  (idle_thr),
        .expired    (idle_exp[g])
      );
    end
  endgenerate

  always_comb begin
    logic [DCPM_RANKS-1:0] awake;
    awake   = '0;
    st_next = st_reg;
    st_next.pre_req = 1'b0;
    st_next.ref_go  = 1'b0;
    case (st_reg.state)
      DCPM_INIT: begin
        // Counting starts at reset release so the low interval always covers the minimum.
        if (st_reg.init_cnt != CNT_W'(INIT_CYC)) begin
          st_next.init_cnt = st_reg.init_cnt + 1'b1;
        end else begin
          st_next.hold_done = 1'b1;
        end
        if (st_reg.hold_done && cfg.cke_release) begin
          st_next.state   = DCPM_RUN;
          st_next.trained = training_valid;
        end
      end
      DCPM_RUN: begin
        for (int r = 0; r < DCPM_RANKS; r++) begin
          // Count down first, so a wake inside a running delay still reloads the full exit time.
          if (st_reg.exit_cnt[r] != 8'h00) begin
            st_next.exit_cnt[r] = st_reg.exit_cnt[r] - 8'h01;
          end
          if (st_reg.pd[r] && (txn_arrive[r] || txn_queued[r])) begin
            st_next.pd[r]       = 1'b0;
            st_next.exit_cnt[r] = 8'(EXIT_CYC);
          end else if (!st_reg.pd[r] && idle_exp[r] && !txn_queued[r] && !txn_arrive[r]) begin
            if (pd_type == DCPM_PD_PRECHARGED && pages_open[r]) begin
              st_next.pre_req = 1'b1;
            end else begin
              st_next.pd[r] = 1'b1;
            end
          end
        end
        if (suspend_req || cond_sr_req || (deep_idle && !cycles_pending && txn_queued == DCPM_MASK_ZERO)) begin
          st_next.state = DCPM_DRAIN;
        end else if (refresh_req && pd_en) begin
          st_next.pd    = '0;
          st_next.state = DCPM_REF_UP;
          for (int r = 0; r < DCPM_RANKS; r++) st_next.exit_cnt[r] = 8'(EXIT_CYC);
        end else if (refresh_req) begin
          st_next.ref_go = 1'b1;
        end
      end
      DCPM_DRAIN: begin
        if (!cycles_pending && txn_queued == DCPM_MASK_ZERO) begin
          st_next.sr    = cfg.populated & ~cfg.graphics_ranks;
          st_next.state = DCPM_SELF_REF;
        end
      end
      DCPM_SELF_REF: begin
        if (!suspend_req && !cond_sr_req && !deep_idle) begin
          st_next.sr      = '0;
          st_next.trained = training_valid;
          st_next.state   = DCPM_RUN;
          for (int r = 0; r < DCPM_RANKS; r++) st_next.exit_cnt[r] = 8'(EXIT_CYC);
        end
      end
      DCPM_REF_UP: begin
        if (st_reg.exit_cnt[0] == 8'h00) begin
          st_next.ref_go = 1'b1;
          st_next.state  = DCPM_REF_WAIT;
        end
        for (int r = 0; r < DCPM_RANKS; r++)
          if (st_reg.exit_cnt[r] != 8'h00) st_next.exit_cnt[r] = st_reg.exit_cnt[r] - 8'h01;
      end
      DCPM_REF_WAIT: begin
        if (refresh_done) begin
          st_next.pd    = cfg.populated;
          st_next.state = DCPM_RUN;
        end
      end
      default: st_next.state = DCPM_INIT;
    endcase

    // Pin drive is registered from the next state, so it changes in the same cycle as the power state.
    for (int r = 0; r < DCPM_RANKS; r++) begin
      awake[r] = (st_next.state != DCPM_INIT) && cfg.populated[r] && !st_next.pd[r] && !st_next.sr[r];
      st_next.allow[r] = awake[r] && st_next.exit_cnt[r] == 8'h00
                         && st_next.state inside {DCPM_RUN, DCPM_REF_WAIT};
    end
    // Supply gating never touches the clock-enable flops, so their level holds.
    st_next.pins.cke       = cs_based ? '0 : awake;
    st_next.pins.cs_pd     = cs_based ? ~awake & cfg.populated : '0;
    // Populated ranks stay driven through power-up: a floating clock enable would not hold the ranks quiet.
    st_next.pins.out_en_n  = ~cfg.populated;
    st_next.pins.rx_enable = cfg.populated & {DCPM_RANKS{st_next.state != DCPM_INIT && !supply_gated}};
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg       <= '0;
      st_reg.state <= DCPM_INIT;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins              = st_reg.pins;
  assign self_refresh      = st_reg.sr;
  assign precharge_all_req = st_reg.pre_req;
  assign refresh_go        = st_reg.ref_go;
  assign cmd_allow         = st_reg.allow;
  assign skip_training     = st_reg.trained;
  assign init_done         = st_reg.hold_done;

  sequence s_refresh_start;
    refresh_req && pd_en && st_reg.state == DCPM_RUN && !suspend_req && !cond_sr_req && !deep_idle;
  endsequence

  a_cke_init_low: assert property (@(posedge clk) disable iff (!rstn)
    !cfg.cke_release |=> pins.cke == '0) else $error("Clock enable rose before release.");
  a_cke_hold_time: assert property (@(posedge clk) disable iff (!rstn)
    !init_done |-> pins.cke == '0) else $error("Clock enable rose before the hold time.");
  a_cs_tech_cke: assert property (@(posedge clk) disable iff (!rstn)
    cs_based |=> pins.cke == '0) else $error("Clock enable driven on a chip-select part.");
  a_unpop_off: assert property (@(posedge clk) disable iff (!rstn)
    $stable(cfg.populated) |=> (pins.cke & ~cfg.populated) == '0 && (pins.out_en_n | cfg.populated) == '1)
    else $error("Unpopulated rank driven.");
  a_rx_unused: assert property (@(posedge clk) disable iff (!rstn)
    $stable(cfg.populated) |=> (pins.rx_enable & ~cfg.populated) == '0) else $error("Receiver on for unused rank.");
  a_ref_powerup: assert property (@(posedge clk) disable iff (!rstn)
    refresh_go |-> pd_en -> st_reg.pd == '0) else $error("Refresh issued to a powered-down rank.");
  a_ref_bracket: assert property (@(posedge clk) disable iff (!rstn)
    s_refresh_start |=> st_reg.pd == '0 ##[1:300] refresh_go) else $error("Refresh not bracketed.");
  a_sr_graphics: assert property (@(posedge clk) disable iff (!rstn)
    (self_refresh & cfg.graphics_ranks) == '0) else $error("Graphics rank put in self-refresh.");
  a_wake_exit: assert property (@(posedge clk) disable iff (!rstn)
    st_reg.state == DCPM_RUN && st_reg.pd[0] && txn_arrive[0] && !suspend_req && !cond_sr_req && !deep_idle
    && !refresh_req |=> !cmd_allow[0]) else $error("Command allowed inside exit delay.");
endmodule

/* verif/dcpm_dram_model.sv */
// Purpose: Behavioural model of the DRAM ranks behind the power manager.
// Assumes: Pages open only on awake ranks; refresh takes a few clocks.
// Notes:   The slow input stretches precharge and refresh answers.
module dcpm_dram_model
  import dcpm_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Controller side
  input  wire dcpm_pkg::dcpm_pins_t  pins,
  input  wire logic                  precharge_all_req,
  input  wire logic                  refresh_go,
  // Test control
  input  wire logic [3:0]            open_req,
  input  wire logic                  slow,
  // Answers
  output logic [DCPM_RANKS-1:0]      pages_open,
  output logic                       refresh_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned pre_cnt;
  int unsigned ref_cnt;

  // A sleeping rank cannot take an activate, so pages open only where clock enable is high.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pages_open   <= '0;
      refresh_done <= 1'b0;
      pre_cnt      <= 0;
      ref_cnt      <= 0;
    end else begin
      refresh_done <= (ref_cnt == 1);
      pages_open   <= (pre_cnt == 1) ? '0 : (pages_open | (open_req & pins.cke));
      if (pre_cnt != 0) pre_cnt <= pre_cnt - 1;
      else if (precharge_all_req) pre_cnt <= slow ? 6 : 1;
      if (ref_cnt != 0) ref_cnt <= ref_cnt - 1;
      else if (refresh_go) ref_cnt <= slow ? 8 : 2;
    end
  end
endmodule

/* verif/dcpm_top_tb.sv */
// Purpose: Self-checking bench for the clock-enable power manager.
// Assumes: Shortened power-up hold; rank 3 unpopulated, rank 1 kept for graphics.
// Notes:   Idle thresholds in the technology loop come from a fixed-seed shift register; the precharged case uses 8.
module dcpm_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dcpm_pkg::*;
  localparam int INIT = 20;
  localparam int EXIT = 4;
  logic clk, rstn, training_valid, suspend_req, cond_sr_req, supply_gated, cycles_pending, refresh_req, slow;
  logic precharge_all_req, refresh_go, skip_training, init_done, refresh_done, saw_pre;
  logic [2:0]  pkg_cstate;
  logic [3:0]  txn_arrive, txn_queued, open_req, self_refresh, cmd_allow, pages_open;
  logic [11:0] thr;
  logic [31:0] rnd;
  dcpm_cfg_t   cfg;
  dcpm_pins_t  pins;
  int          bad_count, checked;

  dcpm_top #(.INIT_CYC(INIT), .EXIT_CYC(EXIT)) u_dcpm_top (.clk(clk), .rstn(rstn), .cfg(cfg),
    .training_valid(training_valid), .pkg_cstate(pkg_cstate), .suspend_req(suspend_req),
    .cond_sr_req(cond_sr_req), .supply_gated(supply_gated), .txn_arrive(txn_arrive), .txn_queued(txn_queued),
    .cycles_pending(cycles_pending), .pages_open(pages_open), .pages_closed_ack(1'b0),
    .refresh_req(refresh_req), .refresh_done(refresh_done), .pins(pins), .self_refresh(self_refresh),
    .precharge_all_req(precharge_all_req), .refresh_go(refresh_go), .cmd_allow(cmd_allow),
    .skip_training(skip_training), .init_done(init_done));
  dcpm_dram_model u_dcpm_dram_model (.clk(clk), .rstn(rstn), .pins(pins), .precharge_all_req(precharge_all_req),
    .refresh_go(refresh_go), .open_req(open_req), .slow(slow), .pages_open(pages_open),
    .refresh_done(refresh_done));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Parts without a clock-enable pin show power state on chip select instead.
  function automatic logic [3:0] cke_exp(input dcpm_tech_t t, input logic [3:0] up);
    return (t == DCPM_DDR5 || t == DCPM_LPDDR5) ? 4'h0 : up;
  endfunction

  function automatic logic [3:0] cs_exp(input dcpm_tech_t t, input logic [3:0] up);
    return (t == DCPM_DDR5 || t == DCPM_LPDDR5) ? (~up & cfg.populated) : 4'h0;
  endfunction

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic chk4(input string what, input logic [3:0] exp, input logic [3:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    chk4(what, {3'h0, exp}, {3'h0, got});
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #(20 * 6000);
    bad_count++;
    end_of_test();
  end

  initial begin
    rstn = 1'b0; cfg = '0; cfg.populated = 4'h7; cfg.graphics_ranks = 4'h2; cfg.tech = DCPM_DDR4;
    training_valid = 1'b1; pkg_cstate = 3'h0; suspend_req = 1'b0; cond_sr_req = 1'b0; supply_gated = 1'b0;
    txn_arrive = 4'h0; txn_queued = 4'h0; cycles_pending = 1'b0; refresh_req = 1'b0; open_req = 4'h0;
    slow = 1'b0; rnd = 32'h1b3b6267; saw_pre = 1'b0; bad_count = 0; checked = 0;
    repeat (6) tick();
    chk4("cke in reset", 4'h0, pins.cke);
    chk4("driver on in reset", 4'h0, pins.out_en_n);
    rstn = 1'b1;
    repeat (INIT - 1) tick();
    chk1("init_done early", 1'b0, init_done);
    repeat (6) tick();
    chk1("init_done", 1'b1, init_done);
    chk4("cke before release", 4'h0, pins.cke);
    cfg.cke_release = 1'b1;
    repeat (3) tick();
    chk4("cke after release", 4'h7, pins.cke);
    chk4("unused rank driver", 4'h8, pins.out_en_n & 4'h8);
    chk4("unused rank receiver", 4'h0, pins.rx_enable & 4'h8);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      thr = 12'h004 + {8'h00, rnd[3:0]};
      cfg.tech = dcpm_tech_t'(k);
      cfg.pd_config = {DCPM_PD_OPEN_PAGE, thr};
      txn_arrive = 4'h7;
      tick();
      txn_arrive = 4'h0;
      txn_queued = 4'h2;
      repeat (thr - 1) tick();
      chk4("cke before expiry", cke_exp(cfg.tech, 4'h7), pins.cke);
      repeat (6) tick();
      chk4("cke after expiry", cke_exp(cfg.tech, 4'h2), pins.cke);
      chk4("cs power-down", cs_exp(cfg.tech, 4'h2), pins.cs_pd);
      // The arrival stays queued until served, so the rank cannot idle out inside its exit delay.
      txn_queued = 4'h1;
      txn_arrive = 4'h1;
      tick();
      txn_arrive = 4'h0;
      tick();
      chk4("wake cke", cke_exp(cfg.tech, 4'h1), pins.cke & 4'h1);
      chk4("allow during exit", 4'h0, cmd_allow & 4'h1);
      repeat (EXIT + 1) tick();
      chk4("allow after exit", 4'h1, cmd_allow & 4'h1);
      txn_queued = 4'h0;
    end
    // Precharged power-down with a slow precharge answer; rank 0 is woken first so a page can open.
    cfg.tech = DCPM_DDR4;
    cfg.pd_config = {DCPM_PD_PRECHARGED, 12'h008};
    slow = 1'b1;
    txn_arrive = 4'h1;
    tick();
    txn_arrive = 4'h0;
    open_req = 4'h1;
    tick();
    open_req = 4'h0;
    for (int i = 0; i < 80 && pins.cke[0] !== 1'b0; i++) begin
      saw_pre = saw_pre | (precharge_all_req === 1'b1);
      tick();
    end
    chk1("precharge issued", 1'b1, saw_pre);
    chk4("pages closed at sleep", 4'h0, pages_open & 4'h1);
    for (int i = 0; i < 60 && pins.cke !== 4'h0; i++) tick();
    refresh_req = 1'b1;
    repeat (2) tick();
    chk4("cke up for refresh", 4'h7, pins.cke);
    for (int i = 0; i < 40 && refresh_go !== 1'b1; i++) tick();
    chk1("refresh_go", 1'b1, refresh_go);
    refresh_req = 1'b0;
    for (int i = 0; i < 40 && pins.cke !== 4'h0; i++) tick();
    chk4("cke down after refresh", 4'h0, pins.cke);
    // Suspend, conditional and deep-idle entry each drain before self-refresh.
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      training_valid = rnd[0];
      cycles_pending = 1'b1;
      suspend_req = (k == 0);
      cond_sr_req = (k == 1);
      pkg_cstate = (k == 2) ? DCPM_CSTATE_C3 : 3'h0;
      repeat (10) tick();
      chk4("no entry while pending", 4'h0, self_refresh);
      cycles_pending = 1'b0;
      for (int i = 0; i < 40 && self_refresh === 4'h0; i++) tick();
      chk4("self-refresh ranks", 4'h5, self_refresh);
      supply_gated = 1'b1;
      repeat (3) tick();
      chk4("cke held while gated", 4'h0, pins.cke & 4'h5);
      chk4("receiver off while gated", 4'h0, pins.rx_enable);
      supply_gated = 1'b0;
      suspend_req = 1'b0;
      cond_sr_req = 1'b0;
      pkg_cstate = 3'h0;
      for (int i = 0; i < 40 && self_refresh !== 4'h0; i++) tick();
      chk4("self-refresh exit", 4'h0, self_refresh);
      chk1("skip training", training_valid, skip_training);
    end
    // With power-down off the refresh goes out on the next edge, as a single pulse.
    cfg.pd_config = {DCPM_PD_NONE, 12'h008};
    refresh_req = 1'b1;
    tick();
    chk1("refresh_go direct", 1'b1, refresh_go);
    refresh_req = 1'b0;
    tick();
    chk1("refresh_go pulse", 1'b0, refresh_go);
    end_of_test();
  end
endmodule
